/* logic/pgo_pkg.sv */
// Shared constants, types and helpers for the pixel gain/offset/region stage
package pgo_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_GAIN = 8'h04;
    localparam logic [7:0] ADDR_OFFS = 8'h08;
    localparam logic [7:0] ADDR_FIRST = 8'h0c;
    localparam logic [7:0] ADDR_COUNT = 8'h10;
    localparam logic [7:0] ADDR_STAT = 8'h14;
    // Field positions
    localparam int CTRL_DEPTH_LSB = 0;
    localparam int CTRL_BIN_BIT = 2;
    localparam int CTRL_SINGLE_BIT = 3;
    localparam int ABS_SEL_BIT = 31;
    localparam int ABS_LSB = 16;
    localparam int STAT_CNT_LSB = 16;

    typedef enum logic [1:0] {
        PGO_D8 = 2'b00,
        PGO_D10 = 2'b01,
        PGO_D12 = 2'b10
    } pgo_depth_t;

    // Gain limits and reset value; 4096 is unity
    localparam logic [13:0] GAIN_MIN = 14'h0aab;
    localparam logic [13:0] GAIN_MAX8 = 14'h3fff;
    localparam logic [13:0] GAIN_MAX10 = 14'h2000;
    localparam logic [13:0] GAIN_MAX12 = 14'h1800;
    localparam logic [13:0] GAIN_RST = 14'h1000;
    localparam int GAIN_SHIFT = 12;
    // Offset limits in 12-bit counts
    localparam logic signed [16:0] OFFS_MAX = 17'sh00fff;
    localparam logic signed [16:0] OFFS_MIN = -17'sh00fff;
    localparam logic [12:0] OFFS_RST = 13'h0000;
    // Region granularity
    localparam logic [13:0] REG_STEP = 14'h0020;
    localparam logic [13:0] REG_STEP_BIN = 14'h0010;
    localparam logic [13:0] REG_MIN = 14'h0100;
    localparam logic [13:0] REG_MIN_BIN = 14'h0080;
    localparam logic [13:0] FIRST_RST = 14'h0001;

    function automatic logic [13:0] pgo_gain_max(pgo_depth_t d);
        unique case (d)
            PGO_D8: return GAIN_MAX8;
            PGO_D10: return GAIN_MAX10;
            default: return GAIN_MAX12;
        endcase
    endfunction : pgo_gain_max

    function automatic logic [13:0] pgo_gain_clamp(logic [13:0] g, pgo_depth_t d);
        if (g < GAIN_MIN)
            return GAIN_MIN;
        if (g > pgo_gain_max(d))
            return pgo_gain_max(d);
        return g;
    endfunction : pgo_gain_clamp

    // 12-bit counts per output count, as a shift
    function automatic logic [2:0] pgo_shift(pgo_depth_t d);
        unique case (d)
            PGO_D8: return 3'h4;
            PGO_D10: return 3'h2;
            default: return 3'h0;
        endcase
    endfunction : pgo_shift

    // Whole dB to setting, 4096*10^(dB/20); zero marks an unsupported value
    function automatic logic [13:0] pgo_db_gain(logic [7:0] db);
        case (db)
            8'hfd: return 14'h0b54;
            8'hfe: return 14'h0cb6;
            8'hff: return 14'h0e43;
            8'h00: return 14'h1000;
            8'h01: return 14'h11f4;
            8'h02: return 14'h1425;
            8'h03: return 14'h169a;
            8'h04: return 14'h195c;
            8'h05: return 14'h1c74;
            8'h06: return 14'h1fed;
            8'h07: return 14'h23d2;
            8'h08: return 14'h2831;
            8'h09: return 14'h2d18;
            8'h0a: return 14'h3299;
            8'h0b: return 14'h38c5;
            8'h0c: return 14'h3fb2;
            default: return 14'h0000;
        endcase
    endfunction : pgo_db_gain
endpackage : pgo_pkg

/* logic/pgo_pixel_proc.sv */
// Per-pixel gain, offset, saturation and depth scaling, one register stage
`timescale 1ns/1ps
`default_nettype none
module pgo_pixel_proc #(
    parameter int SW = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic in_valid,
    input wire logic [11:0] in_data,
    input wire logic [SW-1:0] in_side,
    input wire logic [13:0] gain,
    input wire logic signed [12:0] offset,
    input wire pgo_pkg::pgo_depth_t depth,
    output logic out_valid,
    output logic [11:0] out_data,
    output logic [SW-1:0] out_side
);
    logic [25:0] prod;
    logic signed [16:0] sum;
    logic [11:0] sat;

    assign prod = {14'h0000, in_data} * {12'h000, gain};
    assign sum = $signed({3'b000, prod[25:12]}) + 17'(offset);
    // Clip instead of wrap: a bright pixel must not turn black
    assign sat = (sum < 17'sh00000) ? 12'h000 : (sum > 17'sh00fff) ? 12'hfff : sum[11:0];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            out_valid <= 1'b0;
            out_data <= 12'h000;
            out_side <= '0;
        end
        else
        begin
            out_valid <= in_valid;
            out_side <= in_side;
            out_data <= sat >> pgo_pkg::pgo_shift(depth);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reference built without the multiplier, unity gain only
    logic signed [16:0] ref_sum;
    logic [11:0] ref_clip;
    assign ref_sum = $signed({5'h00, in_data}) + 17'(offset);
    assign ref_clip = (ref_sum < 17'sh00000) ? 12'h000 : (ref_sum > 17'sh00fff) ? 12'hfff : ref_sum[11:0];

    property p_scale;
        @(posedge pclk) disable iff (!presetn)
        in_valid && offset == 13'sh0000 && depth == pgo_pkg::PGO_D12 && prod < 26'h0fff000
        |=> out_data == 12'($past(prod) / 26'h0001000);
    endproperty
    a_scale: assert property (p_scale) else $error("gain ratio not applied");
    property p_offs_8;
        @(posedge pclk) disable iff (!presetn)
        in_valid && gain == pgo_pkg::GAIN_RST && depth == pgo_pkg::PGO_D8 |=> out_data == ($past(ref_clip) >> 4);
    endproperty
    a_offs_8: assert property (p_offs_8) else $error("8-bit offset step wrong");
    property p_offs_10;
        @(posedge pclk) disable iff (!presetn)
        in_valid && gain == pgo_pkg::GAIN_RST && depth == pgo_pkg::PGO_D10 |=> out_data == ($past(ref_clip) >> 2);
    endproperty
    a_offs_10: assert property (p_offs_10) else $error("10-bit offset step wrong");
    property p_offs_12;
        @(posedge pclk) disable iff (!presetn)
        in_valid && gain == pgo_pkg::GAIN_RST && depth == pgo_pkg::PGO_D12 |=> out_data == $past(ref_clip);
    endproperty
    a_offs_12: assert property (p_offs_12) else $error("12-bit offset step wrong");
    property p_sat;
        @(posedge pclk) disable iff (!presetn)
        in_valid && $signed({1'b0, in_data}) + offset > 14'sh0fff && gain >= pgo_pkg::GAIN_RST
        |=> out_data == (12'hfff >> pgo_pkg::pgo_shift($past(depth)));
    endproperty
    a_sat: assert property (p_sat) else $error("overflow not saturated");
endmodule : pgo_pixel_proc
`default_nettype wire

/* logic/pgo_top.sv */
// Pixel stage: APB registers, binning, region crop and gain/offset datapath
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Gain setting never below 2731
// - Gain capped 16383, 8192, 6144 by depth
// - Gain resets to 4096, unity
// - Pixel scaled by gain over 4096
// - Gain writable in dB or raw
// - Offset limited to +-4095, resets zero
// - 8-bit: 16 offset steps per count
// - 10-bit: 4 offset steps per count
// - 12-bit: 1 offset step per count
// - Offset writable in counts or raw
// - Only region pixels are sent
// - Single-line mode sends line A only, line B dropped
// - Binning merges pairs, region in binned pixels
// - Start and length in separate registers
module pgo_top #(
    parameter int LINE_PIXELS = 2048
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pix_valid,
    input wire logic [11:0] pix_data,
    input wire logic pix_line_b,
    input wire logic pix_sol,
    output logic out_valid,
    output logic [11:0] out_data,
    output logic out_line_b,
    output logic out_first
);
    localparam logic [13:0] LINE_W = 14'(LINE_PIXELS);

    pgo_pkg::pgo_depth_t depth_r;
    logic bin_r;
    logic single_r;
    logic [13:0] gain_r;
    logic [12:0] offs_r;
    logic [13:0] first_r;
    logic [13:0] count_r;
    logic rej_r;
    logic [15:0] out_cnt_r;

    ////////////////////////////////////////////////////////////////////////////
    // APB slave, one wait-free access; ready is a flop set in the setup cycle
    logic setup;
    logic wr;
    logic addr_ok;
    logic [31:0] rd_mux;

    assign setup = psel & ~penable & ~pready;
    assign wr = psel & penable & pready & pwrite;
    assign addr_ok = paddr inside {pgo_pkg::ADDR_CTRL, pgo_pkg::ADDR_GAIN, pgo_pkg::ADDR_OFFS,
                                   pgo_pkg::ADDR_FIRST, pgo_pkg::ADDR_COUNT, pgo_pkg::ADDR_STAT};

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            pgo_pkg::ADDR_CTRL: rd_mux = {28'h0, single_r, bin_r, depth_r};
            pgo_pkg::ADDR_GAIN: rd_mux = {18'h0, gain_r};
            pgo_pkg::ADDR_OFFS: rd_mux = {{19{offs_r[12]}}, offs_r};
            pgo_pkg::ADDR_FIRST: rd_mux = {18'h0, first_r};
            pgo_pkg::ADDR_COUNT: rd_mux = {18'h0, count_r};
            pgo_pkg::ADDR_STAT: rd_mux = {out_cnt_r, 15'h0, rej_r};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= setup;
            pslverr <= setup & ~addr_ok;
            prdata <= (setup && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register write checking
    logic w_ctrl;
    logic w_gain;
    logic w_offs;
    logic w_first;
    logic w_count;
    logic depth_ok;
    pgo_pkg::pgo_depth_t depth_new;
    logic bin_new;
    logic [13:0] gain_req;
    logic [13:0] gain_nxt;
    logic signed [16:0] offs_req;
    logic [12:0] offs_nxt;
    logic [13:0] w_cur;
    logic [13:0] w_new;
    logic [13:0] step;
    logic [13:0] min_len;
    logic [14:0] wv;
    logic first_ok;
    logic count_ok;
    logic rej_evt;

    assign w_ctrl = wr && paddr == pgo_pkg::ADDR_CTRL;
    assign w_gain = wr && paddr == pgo_pkg::ADDR_GAIN;
    assign w_offs = wr && paddr == pgo_pkg::ADDR_OFFS;
    assign w_first = wr && paddr == pgo_pkg::ADDR_FIRST;
    assign w_count = wr && paddr == pgo_pkg::ADDR_COUNT;
    assign depth_ok = pwdata[pgo_pkg::CTRL_DEPTH_LSB +: 2] != 2'b11;
    assign depth_new = depth_ok ? pgo_pkg::pgo_depth_t'(pwdata[pgo_pkg::CTRL_DEPTH_LSB +: 2]) : depth_r;
    assign bin_new = pwdata[pgo_pkg::CTRL_BIN_BIT];
    // Binned pixels halve the usable line
    assign w_cur = bin_r ? (LINE_W >> 1) : LINE_W;
    assign w_new = bin_new ? (LINE_W >> 1) : LINE_W;
    assign step = bin_r ? pgo_pkg::REG_STEP_BIN : pgo_pkg::REG_STEP;
    assign min_len = bin_r ? pgo_pkg::REG_MIN_BIN : pgo_pkg::REG_MIN;
    assign wv = {1'b0, pwdata[13:0]};
    assign first_ok = wv[13:0] != 14'h0 && ((wv[13:0] - 14'h1) & (step - 14'h1)) == 14'h0
                      && wv + {1'b0, count_r} <= {1'b0, w_cur} + 15'h1;
    assign count_ok = wv[13:0] >= min_len && (wv[13:0] & (step - 14'h1)) == 14'h0
                      && wv + {1'b0, first_r} <= {1'b0, w_cur} + 15'h1;

    // Absolute field is whole dB, raw field the setting itself
    assign gain_req = pwdata[pgo_pkg::ABS_SEL_BIT] ? pgo_pkg::pgo_db_gain(pwdata[pgo_pkg::ABS_LSB +: 8])
                                                   : pwdata[13:0];
    // Absolute offset is output counts, scaled to 12-bit steps by depth
    assign offs_req = pwdata[pgo_pkg::ABS_SEL_BIT]
                      ? ($signed({{5{pwdata[27]}}, pwdata[27:16]}) <<< pgo_pkg::pgo_shift(depth_r))
                      : $signed({{4{pwdata[12]}}, pwdata[12:0]});

    always_comb
    begin
        gain_nxt = gain_r;
        if (w_gain && gain_req != 14'h0)
            gain_nxt = pgo_pkg::pgo_gain_clamp(gain_req, depth_r);
        else if (w_ctrl)
            gain_nxt = pgo_pkg::pgo_gain_clamp(gain_r, depth_new);
    end

    always_comb
    begin
        offs_nxt = offs_r;
        if (w_offs)
        begin
            if (offs_req > pgo_pkg::OFFS_MAX)
                offs_nxt = pgo_pkg::OFFS_MAX[12:0];
            else if (offs_req < pgo_pkg::OFFS_MIN)
                offs_nxt = pgo_pkg::OFFS_MIN[12:0];
            else
                offs_nxt = offs_req[12:0];
        end
    end

    assign rej_evt = (w_ctrl && !depth_ok)
                   || (w_gain && gain_req != pgo_pkg::pgo_gain_clamp(gain_req, depth_r))
                   || (w_offs && offs_req[12:0] != offs_nxt)
                   || (w_first && !first_ok) || (w_count && !count_ok);

    ////////////////////////////////////////////////////////////////////////////
    // Control registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            depth_r <= pgo_pkg::PGO_D12;
            bin_r <= 1'b0;
            single_r <= 1'b0;
        end
        else if (w_ctrl)
        begin
            depth_r <= depth_new;
            bin_r <= bin_new;
            single_r <= pwdata[pgo_pkg::CTRL_SINGLE_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gain_r <= pgo_pkg::GAIN_RST;
            offs_r <= pgo_pkg::OFFS_RST;
        end
        else
        begin
            gain_r <= gain_nxt;
            offs_r <= offs_nxt;
        end
    end

    // A binning change reopens the full line so the region stays legal
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            first_r <= pgo_pkg::FIRST_RST;
            count_r <= LINE_W;
        end
        else if (w_ctrl && bin_new != bin_r)
        begin
            first_r <= pgo_pkg::FIRST_RST;
            count_r <= w_new;
        end
        else
        begin
            if (w_first && first_ok)
                first_r <= pwdata[13:0];
            if (w_count && count_ok)
                count_r <= pwdata[13:0];
        end
    end

    // Sticky reject flag, write one to clear; a new reject wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rej_r <= 1'b0;
        else if (rej_evt)
            rej_r <= 1'b1;
        else if (wr && paddr == pgo_pkg::ADDR_STAT && pwdata[0])
            rej_r <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Binning and per-line pixel position (1-based)
    logic phase_r;
    logic [11:0] hold_r;
    logic hold_sol_r;
    logic [13:0] pos_r [2];
    logic s1_valid_r;
    logic [11:0] s1_data_r;
    logic s1_line_r;
    logic [13:0] s1_pos_r;
    logic [12:0] pair_sum;
    logic emit_sol;
    logic [13:0] pos_cur;

    assign pair_sum = {1'b0, hold_r} + {1'b0, pix_data};
    assign emit_sol = bin_r ? hold_sol_r : pix_sol;
    assign pos_cur = emit_sol ? 14'h1 : pos_r[pix_line_b] + 14'h1;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            phase_r <= 1'b0;
            hold_r <= 12'h000;
            hold_sol_r <= 1'b0;
            pos_r[0] <= 14'h0;
            pos_r[1] <= 14'h0;
            s1_valid_r <= 1'b0;
            s1_data_r <= 12'h000;
            s1_line_r <= 1'b0;
            s1_pos_r <= 14'h0;
        end
        else
        begin
            s1_valid_r <= 1'b0;
            if (pix_valid && bin_r && (pix_sol || !phase_r))
            begin
                phase_r <= 1'b1;
                hold_r <= pix_data;
                hold_sol_r <= pix_sol;
            end
            else if (pix_valid)
            begin
                phase_r <= 1'b0;
                s1_valid_r <= 1'b1;
                s1_line_r <= pix_line_b;
                s1_data_r <= bin_r ? pair_sum[12:1] : pix_data;
                s1_pos_r <= pos_cur;
                pos_r[pix_line_b] <= pos_cur;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Region crop, then gain and offset
    logic keep;
    assign keep = s1_valid_r && s1_pos_r >= first_r
                  && {1'b0, s1_pos_r} < {1'b0, first_r} + {1'b0, count_r}
                  && !(single_r && s1_line_r);

    pgo_pixel_proc #(
        .SW(2)
    ) u_proc (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(keep),
        .in_data(s1_data_r),
        .in_side({s1_line_r, s1_pos_r == first_r}),
        .gain(gain_r),
        .offset(offs_r),
        .depth(depth_r),
        .out_valid(out_valid),
        .out_data(out_data),
        .out_side({out_line_b, out_first})
    );

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            out_cnt_r <= 16'h0000;
        else if (out_valid)
            out_cnt_r <= out_first ? 16'h0001 : out_cnt_r + 16'h0001;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_gain_min;
        @(posedge pclk) disable iff (!presetn) gain_r >= pgo_pkg::GAIN_MIN;
    endproperty
    a_gain_min: assert property (p_gain_min) else $error("gain below minimum");
    property p_gain_max;
        @(posedge pclk) disable iff (!presetn) gain_r <= pgo_pkg::pgo_gain_max(depth_r);
    endproperty
    a_gain_max: assert property (p_gain_max) else $error("gain above depth limit");
    property p_gain_rst;
        @(posedge pclk) $rose(presetn) |-> gain_r == pgo_pkg::GAIN_RST && offs_r == pgo_pkg::OFFS_RST;
    endproperty
    a_gain_rst: assert property (p_gain_rst) else $error("bad reset gain or offset");
    property p_db;
        @(posedge pclk) disable iff (!presetn)
        w_gain && pwdata[31] && pwdata[23:16] == 8'h00 |=> gain_r == pgo_pkg::GAIN_RST;
    endproperty
    a_db: assert property (p_db) else $error("0 dB not unity");
    property p_offs_range;
        @(posedge pclk) disable iff (!presetn)
        $signed(offs_r) <= 13'sh0fff && $signed(offs_r) >= -13'sh0fff;
    endproperty
    a_offs_range: assert property (p_offs_range) else $error("offset out of range");
    property p_offs_abs;
        @(posedge pclk) disable iff (!presetn)
        w_offs && pwdata[31] && pwdata[27:16] == 12'h001 && depth_r == pgo_pkg::PGO_D8 |=> offs_r == 13'h0010;
    endproperty
    a_offs_abs: assert property (p_offs_abs) else $error("absolute offset scale wrong");
    property p_crop;
        @(posedge pclk) disable iff (!presetn)
        s1_valid_r && (s1_pos_r < first_r || single_r && s1_line_r) |=> !out_valid;
    endproperty
    a_crop: assert property (p_crop) else $error("pixel outside region sent");
    property p_region_wr;
        @(posedge pclk) disable iff (!presetn)
        w_first && !first_ok && !w_ctrl |=> $stable(first_r) ##0 rej_r;
    endproperty
    a_region_wr: assert property (p_region_wr) else $error("illegal start accepted");
    property p_bin_pair;
        @(posedge pclk) disable iff (!presetn)
        bin_r && pix_valid && pix_sol |=> !s1_valid_r;
    endproperty
    a_bin_pair: assert property (p_bin_pair) else $error("binned pixel not paired");

    c_bin: cover property (@(posedge pclk) bin_r && s1_valid_r);
    c_crop: cover property (@(posedge pclk) out_valid && out_first);
    c_single: cover property (@(posedge pclk) single_r && s1_valid_r && s1_line_r);
endmodule : pgo_top
`default_nettype wire

/* bench/pgo_grabber.sv */
// Frame grabber model: counts the pixels it receives and captures the first and last
`timescale 1ns/1ps
`default_nettype none
module pgo_grabber (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic out_valid,
    input wire logic [11:0] out_data,
    input wire logic out_line_b,
    input wire logic out_first
);
    int cnt_r;
    logic [11:0] first_r;
    logic [11:0] last_r;
    logic line_b_r;
    ////////////////////////////////////////////////////////////////
    // Restart on region start, so no clear strobe is needed
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_r <= 0;
            first_r <= 12'h000;
            last_r <= 12'h000;
            line_b_r <= 1'b0;
        end
        else if (out_valid)
        begin
            cnt_r <= out_first ? 1 : cnt_r + 1;
            if (out_first)
            begin
                first_r <= out_data;
            end
            last_r <= out_data;
            line_b_r <= out_line_b;
        end
    end
endmodule : pgo_grabber
`default_nettype wire

/* bench/pixel_gain_offset_roi_crop_tb.sv */
// Self-checking bench for the pixel gain, offset and region stage
`timescale 1ns/1ps
`default_nettype none
module pixel_gain_offset_roi_crop_tb;
    // Short line keeps the run brief
    localparam int LP = 512;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pix_valid;
    logic [11:0] pix_data;
    logic pix_line_b;
    logic pix_sol;
    logic out_valid;
    logic [11:0] out_data;
    logic out_line_b;
    logic out_first;
    logic [31:0] rd;
    logic rd_err;
    int err_total;
    int compares;
    pgo_top #(.LINE_PIXELS(LP)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .pix_valid, .pix_data, .pix_line_b, .pix_sol, .out_valid,
        .out_data, .out_line_b, .out_first);
    pgo_grabber g (.pclk, .presetn, .out_valid, .out_data, .out_line_b, .out_first);
    ////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
        begin
            $display("RESULT: PASS");
        end
        else
        begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
        compares++;
        if (v !== e)
        begin
            err_total++;
            $display("[FAIL] %s expected %0h seen %0h", nm, e, v);
        end
    endtask : chk
    // Request held until the edge that samples pready high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
            begin
                break;
            end
        end
        rd = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (n == 20)
        begin
            err_total++;
            end_of_test();
        end
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask : rchk
    task automatic line(input logic b, input int n, input int v, input int s);
        for (int i = 0; i < n; i++)
        begin
            pix_valid <= 1'b1;
            pix_sol <= (i == 0);
            pix_line_b <= b;
            pix_data <= 12'(v + i * s);
            @(posedge pclk);
        end
        pix_valid <= 1'b0;
        pix_sol <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask : line
    task automatic px(input int v, input logic [11:0] e);
        line(1'b0, 1, v, 0);
        chk("pixel", 32'(e), 32'(g.last_r));
    endtask : px
    ////////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [31:0] mx [3] = '{32'h3fff, 32'h2000, 32'h1800};
        rchk("gain", pgo_pkg::ADDR_GAIN, 32'h1000);
        rchk("offset", pgo_pkg::ADDR_OFFS, 32'h0);
        rchk("first", pgo_pkg::ADDR_FIRST, 32'h1);
        rchk("count", pgo_pkg::ADDR_COUNT, 32'(LP));
        wr(pgo_pkg::ADDR_GAIN, 32'h64);
        rchk("gain min", pgo_pkg::ADDR_GAIN, 32'haab);
        for (int d = 0; d < 3; d++)
        begin
            wr(pgo_pkg::ADDR_CTRL, 32'(d));
            wr(pgo_pkg::ADDR_GAIN, 32'h3fff);
            rchk("gain max", pgo_pkg::ADDR_GAIN, mx[d]);
        end
        wr(pgo_pkg::ADDR_GAIN, 32'h1f40);
        wr(pgo_pkg::ADDR_GAIN, 32'h8000_0000);
        rchk("gain db", pgo_pkg::ADDR_GAIN, 32'h1000);
        apb(1'b0, 8'h20, 32'h0);
        chk("slverr", 32'h1, 32'(rd_err));
        $display("registers done");
    endtask : t_regs
    task automatic t_pix();
        wr(pgo_pkg::ADDR_GAIN, 32'h1800);
        px(1000, 12'h5dc);
        px(3000, 12'hfff);
        wr(pgo_pkg::ADDR_GAIN, 32'h1000);
        wr(pgo_pkg::ADDR_OFFS, 32'h1ffb);
        px(3, 12'h000);
        wr(pgo_pkg::ADDR_OFFS, 32'h1000);
        rchk("offs clamp", pgo_pkg::ADDR_OFFS, 32'hffff_f001);
        wr(pgo_pkg::ADDR_CTRL, 32'h0);
        wr(pgo_pkg::ADDR_OFFS, 32'h8001_0000);
        rchk("offs abs", pgo_pkg::ADDR_OFFS, 32'h10);
        px(1600, 12'h065);
        wr(pgo_pkg::ADDR_CTRL, 32'h1);
        wr(pgo_pkg::ADDR_OFFS, 32'h4);
        px(1600, 12'h191);
        wr(pgo_pkg::ADDR_CTRL, 32'h2);
        wr(pgo_pkg::ADDR_OFFS, 32'h1);
        px(1600, 12'h641);
        wr(pgo_pkg::ADDR_OFFS, 32'h0);
        $display("datapath done");
    endtask : t_pix
    task automatic t_crop();
        wr(pgo_pkg::ADDR_COUNT, 32'h100);
        wr(pgo_pkg::ADDR_FIRST, 32'h21);
        line(1'b0, LP, 0, 1);
        chk("count", 32'h100, 32'(g.cnt_r));
        chk("first", 32'h20, 32'(g.first_r));
        chk("last", 32'h11f, 32'(g.last_r));
        // Clear the sticky flag so the rejects below must set it again
        wr(pgo_pkg::ADDR_STAT, 32'h1);
        apb(1'b0, pgo_pkg::ADDR_STAT, 32'h0);
        chk("stat clr", 32'h0, {31'h0, rd[0]});
        chk("stat cnt", 32'h100, {16'h0, rd[31:16]});
        wr(pgo_pkg::ADDR_FIRST, 32'h22);
        wr(pgo_pkg::ADDR_COUNT, 32'hfa);
        rchk("first kept", pgo_pkg::ADDR_FIRST, 32'h21);
        rchk("count kept", pgo_pkg::ADDR_COUNT, 32'h100);
        wr(pgo_pkg::ADDR_COUNT, 32'h200);
        rchk("bound kept", pgo_pkg::ADDR_COUNT, 32'h100);
        apb(1'b0, pgo_pkg::ADDR_STAT, 32'h0);
        chk("stat", 32'h1, {31'h0, rd[0]});
        wr(pgo_pkg::ADDR_CTRL, 32'ha);
        line(1'b1, LP, 0, 1);
        chk("single b", 32'h0, 32'(g.line_b_r));
        wr(pgo_pkg::ADDR_CTRL, 32'h2);
        line(1'b1, LP, 0, 1);
        chk("dual b", 32'h1, 32'(g.line_b_r));
        chk("dual cnt", 32'h100, 32'(g.cnt_r));
        $display("region done");
    endtask : t_crop
    task automatic t_bin();
        wr(pgo_pkg::ADDR_CTRL, 32'h6);
        rchk("bin first", pgo_pkg::ADDR_FIRST, 32'h1);
        rchk("bin count", pgo_pkg::ADDR_COUNT, 32'h100);
        line(1'b0, LP, 0, 2);
        chk("bin cnt", 32'h100, 32'(g.cnt_r));
        chk("bin first px", 32'h1, 32'(g.first_r));
        chk("bin last px", 32'h3fd, 32'(g.last_r));
        wr(pgo_pkg::ADDR_COUNT, 32'h90);
        rchk("bin count set", pgo_pkg::ADDR_COUNT, 32'h90);
        wr(pgo_pkg::ADDR_FIRST, 32'h11);
        rchk("bin first set", pgo_pkg::ADDR_FIRST, 32'h11);
        $display("binning done");
    endtask : t_bin
    ////////////////////////////////////////////////////////////////
    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pix_valid = 1'b0;
        pix_data = 12'h000;
        pix_line_b = 1'b0;
        pix_sol = 1'b0;
        err_total = 0;
        compares = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_pix();
        t_crop();
        t_bin();
        end_of_test();
    end
endmodule : pixel_gain_offset_roi_crop_tb
`default_nettype wire
